/* File: pkg/sss_consts.vh */
// constants for the stop-sequence selector
// assumes a 40 MHz hclk and an ahb-lite register bus
`ifndef SSS_CONSTS_VH
`define SSS_CONSTS_VH
// register byte offsets
`define SSS_CTRL_OFS 8'h00
`define SSS_EMG_OFS 8'h04
`define SSS_NORM_OFS 8'h08
`define SSS_OPT2_OFS 8'h0c
`define SSS_STAT_OFS 8'h10
`define SSS_SPEED_OFS 8'h14
// control register fields, and the command-error bit of the options2 register
`define SSS_LIM_LSB 0
`define SSS_OTS_LSB 2
`define SSS_SOS_LSB 4
`define SSS_CMDERR_BIT 9
// reset values
`define SSS_CTRL_RST 8'h01
`define SSS_EMG_RST 9'h000
`define SSS_NORM_RST 9'h12c
`define SSS_OPT2_RST 16'h0000
// setting ranges
`define SSS_EMG_MAX 9'h1f4
`define SSS_SOS_MAX 4'h9
`define SSS_OTS_MAX 2'h2
`define SSS_LIM_MAX 2'h2
// stop threshold, mm/s
`define SSS_STOP_MMPS 16'h001e
// timing
`define SSS_CLK_NS 25
`define SSS_CYCLE_NS 25000
`define SSS_CYCLE_CNT ((`SSS_CYCLE_NS + `SSS_CLK_NS - 1) / `SSS_CLK_NS)
`endif

/* File: hw/sss_selector.v */
// stop-sequence selector: over-travel and servo-off braking
// assumes speed, command and status inputs on hclk; limit pins async
`include "sss_consts.vh"
`default_nettype none

module sss_selector (
    // clock and reset
    input wire hclk,
    input wire hresetn,
    // ahb-lite slave
    input wire hsel,
    input wire [7:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg hreadyout,
    output reg hresp,
    output reg [31:0] hrdata,
    // limit pins
    input wire forward_limit_input,
    input wire reverse_limit_input,
    // drive status
    input wire servo_on,
    input wire other_error,
    input wire main_power_lost,
    input wire pole_estimation_active,
    input wire scale_setup_active,
    input wire [15:0] motor_speed,
    input wire [31:0] feedback_pos,
    // host commands
    input wire cmd_valid,
    input wire cmd_forward,
    // braking and control outputs
    output reg dynamic_brake,
    output reg free_run,
    output reg emergency_stop,
    output reg [8:0] thrust_limit,
    output reg force_position_ctrl,
    output reg pos_gen_halt,
    output reg dev_clear,
    output reg dev_clear_pulse,
    output reg [31:0] cmd_position,
    output reg zero_fwd_thrust,
    output reg zero_rev_thrust,
    // command screening
    output reg cmd_accept,
    output reg cmd_reject,
    output reg cmd_error,
    // sequence hand-off
    output reg err38,
    output reg alarm_seq_active,
    output reg power_loss_seq_active
);

localparam ST_RUN = 3'd0;
localparam ST_OT_DEC = 3'd1;
localparam ST_OT_STP = 3'd2;
localparam ST_SO_DEC = 3'd3;
localparam ST_SO_STP = 3'd4;
localparam ST_ALARM = 3'd5;
localparam ST_PWR = 3'd6;

localparam integer CYC_LAST_INT = `SSS_CYCLE_CNT - 1;
localparam [9:0] CYC_LAST = CYC_LAST_INT[9:0];
localparam [7:0] CTRL_RST = `SSS_CTRL_RST;

// brake code: {emergency, dynamic brake, free run}
function [2:0] so_brake;
    input [3:0] seq;
    input stopped;
    begin
        case (seq)
            4'd0, 4'd4: so_brake = 3'b010;
            4'd1, 4'd5: so_brake = stopped ? 3'b010 : 3'b001;
            4'd2, 4'd6: so_brake = stopped ? 3'b001 : 3'b010;
            4'd3, 4'd7: so_brake = 3'b001;
            4'd8: so_brake = stopped ? 3'b010 : 3'b100;
            default: so_brake = stopped ? 3'b001 : 3'b100;
        endcase
    end
endfunction

function [2:0] ot_brake;
    input [1:0] seq;
    begin
        case (seq)
            2'd0: ot_brake = 3'b010;
            2'd1: ot_brake = 3'b001;
            default: ot_brake = 3'b100;
        endcase
    end
endfunction

// registers
reg [1:0] limit_input_mode_reg;
reg [1:0] overtravel_stop_sequence_reg;
reg [3:0] servo_off_stop_sequence_reg;
reg [8:0] emergency_thrust_limit_reg;
reg [8:0] normal_thrust_limit_reg;
reg [15:0] link_function_options2_reg;

// bus data-phase capture
reg wr_pend_reg;
reg [7:0] wr_addr_reg;

// limit pin synchronisers
reg [1:0] lim_meta_reg;
reg [1:0] lim_sync_reg;
wire [1:0] lim_pins;
assign lim_pins = {reverse_limit_input, forward_limit_input};

genvar gi;
generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_sync
        always @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                lim_meta_reg[gi] <= 1'b0;
                lim_sync_reg[gi] <= 1'b0;
            end else begin
                lim_meta_reg[gi] <= lim_pins[gi];
                lim_sync_reg[gi] <= lim_meta_reg[gi];
            end
        end
    end
endgenerate

wire lim_fwd;
wire lim_rev;
wire lim_any;
assign lim_fwd = lim_sync_reg[0];
assign lim_rev = lim_sync_reg[1];
assign lim_any = lim_fwd | lim_rev;

// control cycle enable
reg [9:0] cyc_cnt_reg;
reg cyc_tick_reg;
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        cyc_cnt_reg <= 10'h000;
        cyc_tick_reg <= 1'b0;
    end else if (cyc_cnt_reg == CYC_LAST) begin
        cyc_cnt_reg <= 10'h000;
        cyc_tick_reg <= 1'b1;
    end else begin
        cyc_cnt_reg <= cyc_cnt_reg + 10'h001;
        cyc_tick_reg <= 1'b0;
    end
end

// state and stop latch
reg [2:0] state_reg;
reg [2:0] state_next;
reg stopped_reg;
reg [15:0] speed_reg;

wire in_decel;
wire ot_mode;
wire alarm_now;
wire setup_busy;
assign in_decel = (state_reg == ST_OT_DEC) || (state_reg == ST_SO_DEC);
assign ot_mode = (limit_input_mode_reg == 2'd0);
assign setup_busy = pole_estimation_active | scale_setup_active;
// mode 2 turns any limit into error 38.0
assign alarm_now = other_error | (limit_input_mode_reg == 2'd2 && lim_any);

always @* begin
    state_next = state_reg;
    if (alarm_now) begin
        state_next = ST_ALARM;
    end else begin
        case (state_reg)
            ST_RUN: begin
                if (!servo_on) begin
                    state_next = main_power_lost ? ST_PWR : ST_SO_DEC;
                end else if (ot_mode && lim_any) begin
                    state_next = ST_OT_DEC;
                end
            end
            ST_OT_DEC: begin
                if (!servo_on) begin
                    state_next = ST_SO_DEC;
                end else if (stopped_reg) begin
                    state_next = ST_OT_STP;
                end
            end
            ST_OT_STP: begin
                if (!servo_on) begin
                    state_next = ST_SO_DEC;
                end else if (!(ot_mode && lim_any)) begin
                    state_next = ST_RUN;
                end
            end
            ST_SO_DEC: begin
                if (main_power_lost) begin
                    state_next = ST_PWR;
                end else if (stopped_reg) begin
                    state_next = ST_SO_STP;
                end
            end
            ST_SO_STP: begin
                if (main_power_lost) begin
                    state_next = ST_PWR;
                end else if (servo_on) begin
                    state_next = ST_RUN;
                end
            end
            ST_PWR: begin
                if (!main_power_lost) begin
                    state_next = servo_on ? ST_RUN : ST_SO_STP;
                end
            end
            default: begin
                state_next = servo_on ? ST_RUN : ST_SO_STP;
            end
        endcase
    end
end

always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        state_reg <= ST_RUN;
        stopped_reg <= 1'b0;
        speed_reg <= 16'h0000;
    end else begin
        state_reg <= state_next;
        if (cyc_tick_reg) begin
            speed_reg <= motor_speed;
        end
        // stop latch holds until a new deceleration starts
        if (!in_decel && (state_next == ST_OT_DEC || state_next == ST_SO_DEC)) begin
            stopped_reg <= 1'b0;
        end else if (in_decel && cyc_tick_reg && motor_speed < `SSS_STOP_MMPS) begin
            stopped_reg <= 1'b1;
        end
    end
end

// per-state braking selection
reg [2:0] brake_sel;
reg force_sel;
reg halt_sel;
reg clear_sel;
always @* begin
    brake_sel = 3'b000;
    force_sel = 1'b0;
    halt_sel = 1'b0;
    clear_sel = 1'b0;
    case (state_reg)
        ST_OT_DEC: begin
            brake_sel = ot_brake(overtravel_stop_sequence_reg);
            force_sel = 1'b1;
            halt_sel = 1'b1;
            clear_sel = 1'b1;
        end
        ST_SO_DEC: begin
            brake_sel = so_brake(servo_off_stop_sequence_reg, 1'b0);
            force_sel = 1'b1;
            halt_sel = 1'b1;
            clear_sel = 1'b1;
        end
        ST_SO_STP: begin
            brake_sel = so_brake(servo_off_stop_sequence_reg, 1'b1);
            force_sel = 1'b1;
            halt_sel = 1'b1;
            clear_sel = 1'b1;
        end
        default: begin
            brake_sel = 3'b000;
        end
    endcase
    // no immediate stop during pole or scale setup
    if (brake_sel[2] && setup_busy) begin
        brake_sel = 3'b010;
    end
end

wire [8:0] emg_limit;
assign emg_limit = (emergency_thrust_limit_reg == 9'h000) ?
    normal_thrust_limit_reg : emergency_thrust_limit_reg;

wire inh_fwd;
wire inh_rev;
// over-travel seq 2 keeps usual thrust after stopping
assign inh_fwd = ot_mode && lim_fwd &&
    !(state_reg == ST_OT_STP && overtravel_stop_sequence_reg == 2'd2);
assign inh_rev = ot_mode && lim_rev &&
    !(state_reg == ST_OT_STP && overtravel_stop_sequence_reg == 2'd2);

wire blocked;
assign blocked = (cmd_forward && ot_mode && lim_fwd) ||
    (!cmd_forward && ot_mode && lim_rev);

// registered outputs
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        dynamic_brake <= 1'b0;
        free_run <= 1'b0;
        emergency_stop <= 1'b0;
        thrust_limit <= `SSS_NORM_RST;
        force_position_ctrl <= 1'b0;
        pos_gen_halt <= 1'b0;
        dev_clear <= 1'b0;
        dev_clear_pulse <= 1'b0;
        cmd_position <= 32'h00000000;
        zero_fwd_thrust <= 1'b0;
        zero_rev_thrust <= 1'b0;
        cmd_accept <= 1'b0;
        cmd_reject <= 1'b0;
        cmd_error <= 1'b0;
        err38 <= 1'b0;
        alarm_seq_active <= 1'b0;
        power_loss_seq_active <= 1'b0;
    end else begin
        emergency_stop <= brake_sel[2];
        dynamic_brake <= brake_sel[1];
        free_run <= brake_sel[0];
        thrust_limit <= brake_sel[2] ? emg_limit : normal_thrust_limit_reg;
        force_position_ctrl <= force_sel;
        pos_gen_halt <= halt_sel;
        dev_clear <= clear_sel;
        // stop instant: decel end or emergency stop start
        dev_clear_pulse <= (in_decel && state_next != state_reg) ||
            (brake_sel[2] && !emergency_stop);
        if (clear_sel) begin
            cmd_position <= feedback_pos;
        end
        zero_fwd_thrust <= inh_fwd;
        zero_rev_thrust <= inh_rev;
        cmd_accept <= cmd_valid && !blocked;
        cmd_reject <= cmd_valid && blocked;
        cmd_error <= cmd_valid && blocked &&
            link_function_options2_reg[`SSS_CMDERR_BIT];
        err38 <= (limit_input_mode_reg == 2'd2) && lim_any;
        // from state_reg so flags never lead the brake outputs
        alarm_seq_active <= (state_reg == ST_ALARM);
        power_loss_seq_active <= (state_reg == ST_PWR);
    end
end

// ahb-lite slave, zero wait states
wire addr_ok;
assign addr_ok = hsel && hready && htrans[1];

always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        hreadyout <= 1'b0;
        hresp <= 1'b0;
        hrdata <= 32'h00000000;
        wr_pend_reg <= 1'b0;
        wr_addr_reg <= 8'h00;
    end else begin
        hreadyout <= 1'b1;
        hresp <= 1'b0;
        wr_pend_reg <= addr_ok && hwrite;
        if (addr_ok) begin
            wr_addr_reg <= haddr;
        end
        if (addr_ok && !hwrite) begin
            if (haddr == `SSS_CTRL_OFS) begin
                hrdata <= {24'h000000, servo_off_stop_sequence_reg,
                    overtravel_stop_sequence_reg, limit_input_mode_reg};
            end else if (haddr == `SSS_EMG_OFS) begin
                hrdata <= {23'h000000, emergency_thrust_limit_reg};
            end else if (haddr == `SSS_NORM_OFS) begin
                hrdata <= {23'h000000, normal_thrust_limit_reg};
            end else if (haddr == `SSS_OPT2_OFS) begin
                hrdata <= {16'h0000, link_function_options2_reg};
            end else if (haddr == `SSS_STAT_OFS) begin
                hrdata <= {23'h000000, err38, alarm_seq_active, power_loss_seq_active,
                    lim_rev, lim_fwd, stopped_reg, state_reg};
            end else if (haddr == `SSS_SPEED_OFS) begin
                hrdata <= {16'h0000, speed_reg};
            end else begin
                hrdata <= 32'h00000000;
            end
        end else begin
            hrdata <= 32'h00000000;
        end
    end
end

// register writes; out-of-range settings keep the old value
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        limit_input_mode_reg <= CTRL_RST[`SSS_LIM_LSB+1:`SSS_LIM_LSB];
        overtravel_stop_sequence_reg <= CTRL_RST[`SSS_OTS_LSB+1:`SSS_OTS_LSB];
        servo_off_stop_sequence_reg <= CTRL_RST[`SSS_SOS_LSB+3:`SSS_SOS_LSB];
        emergency_thrust_limit_reg <= `SSS_EMG_RST;
        normal_thrust_limit_reg <= `SSS_NORM_RST;
        link_function_options2_reg <= `SSS_OPT2_RST;
    end else if (wr_pend_reg) begin
        if (wr_addr_reg == `SSS_CTRL_OFS) begin
            if (hwdata[`SSS_LIM_LSB+1:`SSS_LIM_LSB] <= `SSS_LIM_MAX) begin
                limit_input_mode_reg <= hwdata[`SSS_LIM_LSB+1:`SSS_LIM_LSB];
            end
            if (hwdata[`SSS_OTS_LSB+1:`SSS_OTS_LSB] <= `SSS_OTS_MAX) begin
                overtravel_stop_sequence_reg <= hwdata[`SSS_OTS_LSB+1:`SSS_OTS_LSB];
            end
            if (hwdata[`SSS_SOS_LSB+3:`SSS_SOS_LSB] <= `SSS_SOS_MAX) begin
                servo_off_stop_sequence_reg <= hwdata[`SSS_SOS_LSB+3:`SSS_SOS_LSB];
            end
        end else if (wr_addr_reg == `SSS_EMG_OFS) begin
            if (hwdata[31:9] == 23'h000000 && hwdata[8:0] <= `SSS_EMG_MAX) begin
                emergency_thrust_limit_reg <= hwdata[8:0];
            end
        end else if (wr_addr_reg == `SSS_NORM_OFS) begin
            if (hwdata[31:9] == 23'h000000 && hwdata[8:0] <= `SSS_EMG_MAX) begin
                normal_thrust_limit_reg <= hwdata[8:0];
            end
        end else if (wr_addr_reg == `SSS_OPT2_OFS) begin
            link_function_options2_reg <= hwdata[15:0];
        end
    end
end

endmodule

`default_nettype wire

/* File: verif/sss_selector_properties.sv */
// checker for the stop-sequence selector, bound to its ports
// assumes hclk rising edge and hresetn async active low
`default_nettype none
module sss_selector_properties (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // watched signals
    input wire logic cmd_valid,
    input wire logic cmd_accept,
    input wire logic cmd_reject,
    input wire logic cmd_error,
    input wire logic dev_clear,
    input wire logic dev_clear_pulse,
    input wire logic [31:0] cmd_position,
    input wire logic [31:0] feedback_pos,
    input wire logic pos_gen_halt,
    input wire logic force_position_ctrl,
    input wire logic dynamic_brake,
    input wire logic free_run,
    input wire logic emergency_stop,
    input wire logic alarm_seq_active,
    input wire logic power_loss_seq_active,
    input wire logic err38,
    input wire logic pole_estimation_active
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    property p_cmd_answer; cmd_valid |=> (cmd_accept ^ cmd_reject); endproperty
    a_cmd_answer: assert property (p_cmd_answer) else $error("command not answered once");
    property p_cmd_error; cmd_error |-> cmd_reject; endproperty
    a_cmd_error: assert property (p_cmd_error) else $error("error without reject");
    property p_follow; dev_clear && $past(dev_clear) |-> cmd_position == $past(feedback_pos); endproperty
    a_follow: assert property (p_follow) else $error("command position not tracking");
    property p_pulse; dev_clear_pulse |=> !dev_clear_pulse; endproperty
    a_pulse: assert property (p_pulse) else $error("clear pulse too long");
    property p_halt; pos_gen_halt |-> force_position_ctrl; endproperty
    a_halt: assert property (p_halt) else $error("halt without position control");
    property p_brakes;
        !(dynamic_brake && free_run) && !(emergency_stop && (dynamic_brake || free_run));
    endproperty
    a_brakes: assert property (p_brakes) else $error("two braking methods at once");
    property p_alarm;
        alarm_seq_active |-> !power_loss_seq_active && !dynamic_brake && !free_run && !emergency_stop;
    endproperty
    a_alarm: assert property (p_alarm) else $error("alarm not given priority");
    property p_err38; err38 |-> ##[0:2] alarm_seq_active; endproperty
    a_err38: assert property (p_err38) else $error("err38 without alarm");
    property p_setup; pole_estimation_active [*3] |-> !emergency_stop; endproperty
    a_setup: assert property (p_setup) else $error("emergency stop during setup");
    c_reject: cover property (cmd_reject);
    c_pulse: cover property (dev_clear_pulse);
    c_err38: cover property (err38);
endmodule
bind sss_selector sss_selector_properties u_props (.hclk(hclk), .hresetn(hresetn), .cmd_valid(cmd_valid),
    .cmd_accept(cmd_accept), .cmd_reject(cmd_reject), .cmd_error(cmd_error), .dev_clear(dev_clear),
    .dev_clear_pulse(dev_clear_pulse), .cmd_position(cmd_position), .feedback_pos(feedback_pos),
    .pos_gen_halt(pos_gen_halt), .force_position_ctrl(force_position_ctrl), .dynamic_brake(dynamic_brake),
    .free_run(free_run), .emergency_stop(emergency_stop), .alarm_seq_active(alarm_seq_active),
    .power_loss_seq_active(power_loss_seq_active), .err38(err38), .pole_estimation_active(pole_estimation_active));
`default_nettype wire

/* File: verif/sss_host_model.sv */
// host controller model: issues one-cycle motion commands
// assumes the bench calls send only after reset is over
`default_nettype none
module sss_host_model (
    // clock
    input wire logic hclk,
    // command pins
    output logic cmd_valid,
    output logic cmd_forward
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        cmd_valid = 1'b0;
        cmd_forward = 1'b0;
    end
    // the bench picks the direction; blocked ones are sent on purpose
    task automatic send(input logic fwd);
        @(posedge hclk);
        cmd_valid <= 1'b1;
        cmd_forward <= fwd;
        @(posedge hclk);
        cmd_valid <= 1'b0;
        // released direction must not linger as a valid-looking value
        cmd_forward <= ~fwd;
    endtask
    // no interpolated feed is ever issued, so no coordinate re-set is needed
endmodule
`default_nettype wire

/* File: verif/testbench.sv */
// self-checking bench for the stop-sequence selector
// assumes zero-wait ahb-lite slave and 1000-clock control ticks
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, servo_on = 1'b1;
    logic other_error = 1'b0, main_power_lost = 1'b0, pole_estimation_active = 1'b0, scale_setup_active = 1'b0;
    logic forward_limit_input = 1'b0, reverse_limit_input = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'b00;
    logic [31:0] hwdata = 32'h0, hrdata, q, feedback_pos = 32'h0, cmd_position;
    logic [15:0] motor_speed = 16'h0064;
    logic [8:0] thrust_limit;
    logic hreadyout, hresp, cmd_valid, cmd_forward, dynamic_brake, free_run, emergency_stop;
    logic force_position_ctrl, pos_gen_halt, dev_clear, dev_clear_pulse, zero_fwd_thrust, zero_rev_thrust;
    logic cmd_accept, cmd_reject, cmd_error, err38, alarm_seq_active, power_loss_seq_active;
    int bad_count = 0, samples_checked = 0;
    logic [7:0] adr [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h18, 8'h04, 8'h04, 8'h00};
    logic [31:0] wd [8] = '{0, 0, 0, 0, 0, 32'h1f5, 32'h1f4, 32'ha1};
    logic [31:0] ex [8] = '{32'h1, 0, 32'h12c, 0, 0, 0, 32'h1f4, 32'h1};

    always #12.5 hclk = ~hclk;
    always @(posedge hclk) feedback_pos <= feedback_pos + 32'h3;

    sss_host_model u_host (.hclk(hclk), .cmd_valid(cmd_valid), .cmd_forward(cmd_forward));
    sss_selector i_sss_selector (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .forward_limit_input(forward_limit_input),
        .reverse_limit_input(reverse_limit_input), .servo_on(servo_on), .other_error(other_error),
        .main_power_lost(main_power_lost), .pole_estimation_active(pole_estimation_active),
        .scale_setup_active(scale_setup_active),
        .motor_speed(motor_speed), .feedback_pos(feedback_pos), .cmd_valid(cmd_valid),
        .cmd_forward(cmd_forward), .dynamic_brake(dynamic_brake), .free_run(free_run),
        .emergency_stop(emergency_stop), .thrust_limit(thrust_limit), .force_position_ctrl(force_position_ctrl),
        .pos_gen_halt(pos_gen_halt), .dev_clear(dev_clear), .dev_clear_pulse(dev_clear_pulse),
        .cmd_position(cmd_position), .zero_fwd_thrust(zero_fwd_thrust), .zero_rev_thrust(zero_rev_thrust),
        .cmd_accept(cmd_accept), .cmd_reject(cmd_reject), .cmd_error(cmd_error), .err38(err38),
        .alarm_seq_active(alarm_seq_active), .power_loss_seq_active(power_loss_seq_active));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge hclk);
        #1;
    endtask
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= a;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        r = hrdata;
    endtask
    // slow speed must be latched at a control tick, so allow a bit over one
    task automatic wait_pulse();
        int k;
        k = 0;
        while (dev_clear_pulse !== 1'b1 && k < 1200) begin
            @(posedge hclk);
            #1;
            k++;
        end
        chk(32'(k < 1200), 32'h1);
        tick(2);
    endtask
    task automatic cmd(input logic fwd, input logic [2:0] exp);
        u_host.send(fwd);
        #1;
        chk(32'({cmd_accept, cmd_reject, cmd_error}), 32'(exp));
    endtask

    initial begin
        #1000000;
        bad_count++;
        wrap_up();
    end

    initial begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        tick(2);
        for (int i = 0; i < 8; i++) begin
            if (i > 4) xfer(1'b1, adr[i], wd[i], q);
            xfer(1'b0, adr[i], 32'h0, q);
            chk(q, ex[i]);
            chk(32'(hresp), 32'h0);
        end
        $display("register test done");
        for (int s = 0; s < 10; s++) begin
            logic dba;
            dba = (s < 8) ? (s % 4 < 2) : (s == 8);
            xfer(1'b1, 8'h00, 32'(1 + (s << 4)), q);
            @(posedge hclk) motor_speed <= 16'h0064;
            @(posedge hclk) servo_on <= 1'b0;
            tick(4);
            chk(32'({dynamic_brake, free_run, emergency_stop}), 32'({s < 8 && !s[0], s < 8 && s[0], s > 7}));
            chk(32'({force_position_ctrl, pos_gen_halt, dev_clear}), 32'h7);
            if (s > 7) chk(32'(thrust_limit), 32'h1f4);
            @(posedge hclk) motor_speed <= 16'h0014;
            wait_pulse();
            chk(32'({dynamic_brake, free_run, force_position_ctrl, dev_clear}), 32'({dba, !dba, 2'b11}));
            @(posedge hclk) servo_on <= 1'b1;
            tick(3);
        end
        $display("servo-off test done");
        xfer(1'b1, 8'h04, 32'h0, q);
        xfer(1'b1, 8'h00, 32'h08, q);
        @(posedge hclk) motor_speed <= 16'h0064;
        @(posedge hclk) forward_limit_input <= 1'b1;
        tick(6);
        chk(32'({force_position_ctrl, pos_gen_halt, emergency_stop, dev_clear}), 32'hf);
        chk(32'(thrust_limit), 32'h12c);
        @(posedge hclk) motor_speed <= 16'h0014;
        wait_pulse();
        chk(32'({force_position_ctrl, pos_gen_halt, emergency_stop, dev_clear, zero_fwd_thrust}), 32'h0);
        cmd(1'b1, 3'b010);
        xfer(1'b1, 8'h0c, 32'h200, q);
        cmd(1'b1, 3'b011);
        cmd(1'b0, 3'b100);
        xfer(1'b1, 8'h00, 32'h00, q);
        tick(4);
        chk(32'({zero_fwd_thrust, zero_rev_thrust}), 32'h2);
        xfer(1'b1, 8'h00, 32'h01, q);
        tick(4);
        cmd(1'b1, 3'b100);
        xfer(1'b1, 8'h00, 32'h02, q);
        tick(4);
        chk(32'({err38, alarm_seq_active, dynamic_brake}), 32'h6);
        $display("over-travel test done");
        xfer(1'b1, 8'h00, 32'h81, q);
        @(posedge hclk) pole_estimation_active <= 1'b1;
        @(posedge hclk) servo_on <= 1'b0;
        tick(4);
        chk(32'({dynamic_brake, free_run, emergency_stop}), 32'h4);
        chk(cmd_position, feedback_pos - 32'h3);
        @(posedge hclk) scale_setup_active <= 1'b1;
        @(posedge hclk) pole_estimation_active <= 1'b0;
        tick(3);
        chk(32'({dynamic_brake, free_run, emergency_stop}), 32'h4);
        @(posedge hclk) main_power_lost <= 1'b1;
        tick(4);
        chk(32'({power_loss_seq_active, dynamic_brake, free_run, emergency_stop}), 32'h8);
        @(posedge hclk) other_error <= 1'b1;
        tick(4);
        chk(32'({alarm_seq_active, power_loss_seq_active}), 32'h2);
        $display("fault test done");
        wrap_up();
    end
endmodule
`default_nettype wire
